// >>> logic/psom_top.sv
// Output multiplexer and driver control for general pin seven.
// Assumes status inputs come from core-clock logic, remote pins are async.
`timescale 1ns/1ps
`default_nettype none
// What this block does
// - Decode source group from control bits 4:2
// - Select field 7:5 picks signal within group
// - Receive selects 0-3 forward remote pins
// - Receive selects 4-7: lock, pass, frame, line
// - Status: value, lock OR, lock AND, pass AND, frame sync
// - Transmit selects 0/1: pass AND / OR
// - Transmit line valid 3, frame valid 2
// - Transmit 4 synchronized, 5 interrupt, 6-7 reserved
// - Bit 1 drive value, bit 0 enable
// - Control register 0x17 resets to zero
module psom_top (
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic [psom_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [psom_pkg::DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [psom_pkg::DATA_W-1:0] reg_rdata,
  input wire logic [psom_pkg::RX_PORTS*psom_pkg::REMOTE_PINS-1:0] rx_remote_pins,
  input wire logic [psom_pkg::RX_PORTS-1:0] rx_lock,
  input wire logic [psom_pkg::RX_PORTS-1:0] rx_pass,
  input wire logic [psom_pkg::RX_PORTS-1:0] rx_frame_valid,
  input wire logic [psom_pkg::RX_PORTS-1:0] rx_line_valid,
  input wire logic [psom_pkg::RX_PORTS-1:0] rx_port_enable,
  input wire logic frame_sync_signal,
  input wire logic [psom_pkg::TX_PORTS*psom_pkg::RX_PORTS-1:0] tx_rx_map,
  input wire logic [psom_pkg::TX_PORTS-1:0] tx_frame_valid,
  input wire logic [psom_pkg::TX_PORTS-1:0] tx_line_valid,
  input wire logic [psom_pkg::TX_PORTS-1:0] tx_synchronized,
  input wire logic [psom_pkg::TX_PORTS-1:0] tx_interrupt,
  output logic general_pin_seven_out,
  output logic general_pin_seven_oe
);
  import psom_pkg::*;

  typedef struct packed {
    logic [DATA_W-1:0] ctl;
    logic pin_out;
    logic pin_oe;
    logic rsvd_sel;
    logic [DATA_W-1:0] rdata;
  } psom_state_s;

  psom_state_s st;
  psom_state_s next_st;

  logic [RX_PORTS*REMOTE_PINS-1:0] remote_sync;
  logic [2:0] pin_source_group;
  logic [2:0] pin_signal_select;
  logic pin_register_value;
  logic pin_output_drive_enable;
  logic [1:0] rx_idx;
  logic tx_idx;
  logic [RX_PORTS-1:0] tx_map_sel;
  logic [REMOTE_PINS-1:0] rx_pins_sel;
  logic mux_value;
  logic mux_rsvd;
  logic [DATA_W-1:0] stat_word;

  // Remote pins come over the link from another clock
  psom_sync #(
    .WIDTH(RX_PORTS*REMOTE_PINS)
  ) u_remote_sync (
    .sys_clk(sys_clk),
    .srst(srst),
    .async_in(rx_remote_pins),
    .sync_out(remote_sync)
  );

  // Control fields
  assign pin_source_group = st.ctl[SRC_MSB:SRC_LSB];
  assign pin_signal_select = st.ctl[SEL_MSB:SEL_LSB];
  assign pin_register_value = st.ctl[VAL_BIT];
  assign pin_output_drive_enable = st.ctl[EN_BIT];
  assign rx_idx = pin_source_group[1:0];
  assign tx_idx = pin_source_group[0];
  assign tx_map_sel = tx_rx_map[tx_idx*RX_PORTS +: RX_PORTS];
  assign rx_pins_sel = remote_sync[rx_idx*REMOTE_PINS +: REMOTE_PINS];

  // Signal multiplexer; reserved codes give low
  always_comb begin
    mux_value = 1'b0;
    mux_rsvd = 1'b0;
    if (pin_source_group <= SRC_RX3) begin
      if (pin_signal_select <= SEL_RX_PIN3) begin
        mux_value = rx_pins_sel[pin_signal_select[1:0]];
      end else begin
        unique case (pin_signal_select)
          SEL_RX_LOCK: mux_value = rx_lock[rx_idx];
          SEL_RX_PASS: mux_value = rx_pass[rx_idx];
          SEL_RX_FV: mux_value = rx_frame_valid[rx_idx];
          SEL_RX_LV: mux_value = rx_line_valid[rx_idx];
          default: mux_value = 1'b0;
        endcase
      end
    end else if (pin_source_group == SRC_DEV) begin
      unique case (pin_signal_select)
        SEL_DEV_VAL: mux_value = pin_register_value;
        SEL_DEV_LOCK_OR: mux_value = |(rx_lock & rx_port_enable);
        SEL_DEV_LOCK_AND: mux_value = &(rx_lock | ~rx_port_enable);
        SEL_DEV_PASS_AND: mux_value = &(rx_pass | ~rx_port_enable);
        SEL_DEV_FSYNC: mux_value = frame_sync_signal;
        default: mux_rsvd = 1'b1;
      endcase
    end else if (pin_source_group == SRC_RSVD) begin
      mux_rsvd = 1'b1;
    end else begin
      unique case (pin_signal_select)
        SEL_TX_PASS_AND: mux_value = &(rx_pass | ~tx_map_sel);
        SEL_TX_PASS_OR: mux_value = |(rx_pass & tx_map_sel);
        SEL_TX_FV: mux_value = tx_frame_valid[tx_idx];
        SEL_TX_LV: mux_value = tx_line_valid[tx_idx];
        SEL_TX_SYNC: mux_value = tx_synchronized[tx_idx];
        SEL_TX_IRQ: mux_value = tx_interrupt[tx_idx];
        default: mux_rsvd = 1'b1;
      endcase
    end
  end

  // Read view of the block's own state
  always_comb begin
    stat_word = STAT_RESET;
    stat_word[STAT_OUT_BIT] = st.pin_out;
    stat_word[STAT_OE_BIT] = st.pin_oe;
    stat_word[STAT_RSVD_BIT] = st.rsvd_sel;
  end

  // Next state: register writes, reads and the pin driver
  always_comb begin
    next_st = st;
    if (reg_wr && reg_addr == CTL_ADDR) begin
      next_st.ctl = reg_wdata;
    end
    next_st.rdata = '0;
    if (reg_rd) begin
      if (reg_addr == CTL_ADDR) begin
        next_st.rdata = st.ctl;
      end else if (reg_addr == STAT_ADDR) begin
        next_st.rdata = stat_word;
      end
    end
    next_st.pin_oe = pin_output_drive_enable;
    next_st.pin_out = mux_value & ~mux_rsvd;
    next_st.rsvd_sel = mux_rsvd;
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      st.ctl <= CTL_RESET;
      st.pin_out <= 1'b0;
      st.pin_oe <= 1'b0;
      st.rsvd_sel <= 1'b0;
      st.rdata <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign reg_rdata = st.rdata;
  assign general_pin_seven_out = st.pin_out;
  assign general_pin_seven_oe = st.pin_oe;

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (srst);

  a_reset_ctl_zero: assert property (
    $past(srst) |-> (st.ctl == CTL_RESET && !general_pin_seven_oe)
  ) else $error("Control not zero after reset");

  a_write_then_read: assert property (
    (reg_wr && reg_addr == CTL_ADDR) ##1 (reg_rd && reg_addr == CTL_ADDR && !reg_wr)
      |=> reg_rdata == $past(reg_wdata, 2)
  ) else $error("Control readback mismatch");

  a_enable_follows: assert property (
    (reg_wr && reg_addr == CTL_ADDR) |-> ##2 general_pin_seven_oe == $past(reg_wdata[EN_BIT], 2)
  ) else $error("Output enable does not follow write");

  a_rx_remote_pin: assert property (
    (pin_source_group <= SRC_RX3 && pin_signal_select <= SEL_RX_PIN3)
      |=> general_pin_seven_out
        == $past(remote_sync[rx_idx*REMOTE_PINS + int'(pin_signal_select)])
  ) else $error("Remote pin not forwarded");

  a_rx_lock_out: assert property (
    (pin_source_group <= SRC_RX3 && pin_signal_select == SEL_RX_LOCK)
      |=> general_pin_seven_out == $past(rx_lock[rx_idx])
  ) else $error("Receive lock not driven");

  a_dev_lock_and: assert property (
    (pin_source_group == SRC_DEV && pin_signal_select == SEL_DEV_LOCK_AND
      && rx_port_enable != '0 && (rx_lock & rx_port_enable) != rx_port_enable)
      |=> !general_pin_seven_out
  ) else $error("Lock AND high with an enabled port unlocked");

  a_dev_value_out: assert property (
    (pin_source_group == SRC_DEV && pin_signal_select == SEL_DEV_VAL)
      |=> general_pin_seven_out == $past(st.ctl[VAL_BIT])
  ) else $error("Register value not driven");

  a_dev_fsync_out: assert property (
    (pin_source_group == SRC_DEV && pin_signal_select == SEL_DEV_FSYNC)
      |=> general_pin_seven_out == $past(frame_sync_signal)
  ) else $error("Frame sync not driven");

  a_tx_pass_or: assert property (
    (pin_source_group >= SRC_TX0 && pin_signal_select == SEL_TX_PASS_OR)
      |=> general_pin_seven_out == $past(|(rx_pass & tx_map_sel))
  ) else $error("Transmit pass OR wrong");

  a_tx_line_valid: assert property (
    (pin_source_group == SRC_TX1 && pin_signal_select == SEL_TX_LV)
      |=> general_pin_seven_out == $past(tx_line_valid[1])
  ) else $error("Transmit line valid wrong");

  a_tx_irq_out: assert property (
    (pin_source_group == SRC_TX0 && pin_signal_select == SEL_TX_IRQ)
      |=> general_pin_seven_out == $past(tx_interrupt[0])
  ) else $error("Transmit interrupt wrong");

  a_rsvd_low: assert property (
    (pin_source_group == SRC_RSVD) [*2] |=> (!general_pin_seven_out && st.rsvd_sel)
  ) else $error("Reserved source not low");

  a_group_decode: assert property (
    (pin_source_group == SRC_DEV && pin_signal_select == SEL_DEV_LOCK_OR)
      |=> general_pin_seven_out == $past(|(rx_lock & rx_port_enable))
  ) else $error("Device status group decode wrong");

  a_select_field: assert property (
    (pin_source_group <= SRC_RX3 && pin_signal_select == SEL_RX_FV)
      |=> general_pin_seven_out == $past(rx_frame_valid[rx_idx])
  ) else $error("Select field decode wrong");

  a_rx_pass_out: assert property (
    (pin_source_group <= SRC_RX3 && pin_signal_select == SEL_RX_PASS)
      |=> general_pin_seven_out == $past(rx_pass[rx_idx])
  ) else $error("Receive pass not driven");

  a_rx_line_valid: assert property (
    (pin_source_group <= SRC_RX3 && pin_signal_select == SEL_RX_LV)
      |=> general_pin_seven_out == $past(rx_line_valid[rx_idx])
  ) else $error("Receive line valid not driven");

  a_dev_pass_and: assert property (
    (pin_source_group == SRC_DEV && pin_signal_select == SEL_DEV_PASS_AND)
      |=> general_pin_seven_out == $past(&(rx_pass | ~rx_port_enable))
  ) else $error("Device pass AND wrong");

  a_dev_rsvd_low: assert property (
    (pin_source_group == SRC_DEV && pin_signal_select > SEL_DEV_FSYNC)
      |=> (!general_pin_seven_out && st.rsvd_sel)
  ) else $error("Reserved status select not low");

  a_tx_pass_and: assert property (
    (pin_source_group >= SRC_TX0 && pin_signal_select == SEL_TX_PASS_AND)
      |=> general_pin_seven_out == $past(&(rx_pass | ~tx_map_sel))
  ) else $error("Transmit pass AND wrong");

  a_tx_frame_valid: assert property (
    (pin_source_group == SRC_TX0 && pin_signal_select == SEL_TX_FV)
      |=> general_pin_seven_out == $past(tx_frame_valid[0])
  ) else $error("Transmit frame valid wrong");

  a_tx_sync_out: assert property (
    (pin_source_group >= SRC_TX0 && pin_signal_select == SEL_TX_SYNC)
      |=> general_pin_seven_out == $past(tx_synchronized[tx_idx])
  ) else $error("Transmit synchronized wrong");

  a_tx_rsvd_low: assert property (
    (pin_source_group >= SRC_TX0 && pin_signal_select > SEL_TX_IRQ)
      |=> (!general_pin_seven_out && st.rsvd_sel)
  ) else $error("Reserved transmit select not low");

  a_oe_only_by_write: assert property (
    !(reg_wr && reg_addr == CTL_ADDR)
      |=> ##1 $stable(general_pin_seven_oe)
  ) else $error("Output enable changed without a write");

  a_reset_pin_low: assert property (
    $past(srst) |-> (!general_pin_seven_out && reg_rdata == '0)
  ) else $error("Pin or read data not low after reset");

  a_rsvd_keeps_oe: assert property (
    (pin_source_group == SRC_RSVD)
      |=> general_pin_seven_oe == $past(pin_output_drive_enable)
  ) else $error("Reserved source disturbed the enable");

  a_src_tx_group: assert property (
    (pin_source_group == SRC_TX0 && pin_signal_select == SEL_TX_LV)
      |=> general_pin_seven_out == $past(tx_line_valid[0])
  ) else $error("Transmit group decode wrong");

endmodule
`default_nettype wire

// >>> logic/psom_pkg.sv
// Constants for the pin seven output multiplexer.
// Assumes an 8-bit register port and one 100 MHz core clock.
package psom_pkg;

  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;
  localparam int RX_PORTS = 4;
  localparam int TX_PORTS = 2;
  localparam int REMOTE_PINS = 4;

  // Register offsets
  localparam logic [7:0] CTL_ADDR = 8'h17;
  localparam logic [7:0] STAT_ADDR = 8'h30;
  localparam logic [7:0] CTL_RESET = 8'h00;
  localparam logic [7:0] STAT_RESET = 8'h00;

  // Control field positions
  localparam int SEL_LSB = 5;
  localparam int SEL_MSB = 7;
  localparam int SRC_LSB = 2;
  localparam int SRC_MSB = 4;
  localparam int VAL_BIT = 1;
  localparam int EN_BIT = 0;

  // Status field positions
  localparam int STAT_OUT_BIT = 0;
  localparam int STAT_OE_BIT = 1;
  localparam int STAT_RSVD_BIT = 2;

  // Source group codes
  localparam logic [2:0] SRC_RX0 = 3'h0;
  localparam logic [2:0] SRC_RX3 = 3'h3;
  localparam logic [2:0] SRC_DEV = 3'h4;
  localparam logic [2:0] SRC_RSVD = 3'h5;
  localparam logic [2:0] SRC_TX0 = 3'h6;
  localparam logic [2:0] SRC_TX1 = 3'h7;

  // Receive port group selects
  localparam logic [2:0] SEL_RX_PIN3 = 3'h3;
  localparam logic [2:0] SEL_RX_LOCK = 3'h4;
  localparam logic [2:0] SEL_RX_PASS = 3'h5;
  localparam logic [2:0] SEL_RX_FV = 3'h6;
  localparam logic [2:0] SEL_RX_LV = 3'h7;

  // Device status group selects
  localparam logic [2:0] SEL_DEV_VAL = 3'h0;
  localparam logic [2:0] SEL_DEV_LOCK_OR = 3'h1;
  localparam logic [2:0] SEL_DEV_LOCK_AND = 3'h2;
  localparam logic [2:0] SEL_DEV_PASS_AND = 3'h3;
  localparam logic [2:0] SEL_DEV_FSYNC = 3'h4;

  // Transmit port group selects
  localparam logic [2:0] SEL_TX_PASS_AND = 3'h0;
  localparam logic [2:0] SEL_TX_PASS_OR = 3'h1;
  localparam logic [2:0] SEL_TX_FV = 3'h2;
  localparam logic [2:0] SEL_TX_LV = 3'h3;
  localparam logic [2:0] SEL_TX_SYNC = 3'h4;
  localparam logic [2:0] SEL_TX_IRQ = 3'h5;

  // Synchroniser depth in cycles
  localparam int SYNC_STAGES = 2;

endpackage

// >>> logic/psom_sync.sv
// Two-flop synchroniser for a vector of asynchronous levels.
// Assumes each bit is an independent level; no word coherency.
`timescale 1ns/1ps
`default_nettype none
module psom_sync #(
  parameter int WIDTH = 16
) (
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  import psom_pkg::*;

  if (WIDTH < 1) begin : g_bad_width
    $error("psom_sync: WIDTH must be at least 1");
  end

  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] stable;
  } psom_sync_s;

  psom_sync_s st;
  psom_sync_s next_st;

  // First stage is read only by the second stage
  always_comb begin
    next_st = st;
    next_st.meta = async_in;
    next_st.stable = st.meta;
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign sync_out = st.stable;

endmodule
`default_nettype wire

// >>> tb/psom_pin_watch.sv
// Board-side observer of general pin seven.
// Assumes a board pull-down holds the pin low when undriven.
`timescale 1ns/1ps
`default_nettype none
module psom_pin_watch (
  input wire logic pin_out,
  input wire logic pin_oe,
  output logic pin_level
);
  // Undriven pin falls to the pull-down level
  assign pin_level = pin_oe ? pin_out : 1'b0;
endmodule
`default_nettype wire

// >>> tb/tb_psom_top.sv
// Self-checking bench for the pin seven output multiplexer.
// Assumes psom_pkg and psom_top are compiled first.
`timescale 1ns/1ps
`default_nettype none
module tb_psom_top;
  import psom_pkg::*;
  logic sys_clk = 1'b0;
  logic srst = 1'b1;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic [7:0] reg_rdata;
  logic [63:0] stim = 64'h0;
  logic pin_out;
  logic pin_oe;
  logic pin_level;
  int num_errors = 0;
  int cmp_count = 0;
  int cyc = 0;
  logic [63:0] pats [4] = '{64'h0, '1, 64'h0005_a5f3_96e1_3cc3, 64'h001a_5a2c_6f1e_c33c};

  initial forever #5 sys_clk = ~sys_clk;

  psom_top i_dut (
    .sys_clk(sys_clk),
    .srst(srst),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .reg_wr(reg_wr),
    .reg_rd(reg_rd),
    .reg_rdata(reg_rdata),
    .rx_remote_pins(stim[15:0]),
    .rx_lock(stim[19:16]),
    .rx_pass(stim[23:20]),
    .rx_frame_valid(stim[27:24]),
    .rx_line_valid(stim[31:28]),
    .rx_port_enable(stim[35:32]),
    .frame_sync_signal(stim[36]),
    .tx_rx_map(stim[44:37]),
    .tx_frame_valid(stim[46:45]),
    .tx_line_valid(stim[48:47]),
    .tx_synchronized(stim[50:49]),
    .tx_interrupt(stim[52:51]),
    .general_pin_seven_out(pin_out),
    .general_pin_seven_oe(pin_oe)
  );

  psom_pin_watch i_pin (
    .pin_out(pin_out),
    .pin_oe(pin_oe),
    .pin_level(pin_level)
  );

  // Reference: bit 1 reserved selection, bit 0 pin value
  function automatic logic [1:0] ref_pin(input logic [7:0] c, input logic [63:0] s);
    logic [2:0] sr;
    logic [2:0] sl;
    logic [3:0] m;
    logic [3:0] en;
    int p;
    int t;
    sr = c[4:2];
    sl = c[7:5];
    p = int'(sr[1:0]);
    t = int'(sr[0]);
    m = sr[0] ? s[44:41] : s[40:37];
    en = s[35:32];
    ref_pin = 2'b00;
    if (!sr[2]) begin
      ref_pin[0] = sl[2] ? s[16 + int'(sl[1:0]) * 4 + p] : s[p * 4 + int'(sl[1:0])];
    end else if (sr == 3'h4) begin
      case (sl)
        3'h0: ref_pin[0] = c[1];
        3'h1: ref_pin[0] = |(s[19:16] & en);
        3'h2: ref_pin[0] = &(s[19:16] | ~en);
        3'h3: ref_pin[0] = &(s[23:20] | ~en);
        3'h4: ref_pin[0] = s[36];
        default: ref_pin = 2'b10;
      endcase
    end else if (sr == 3'h5) begin
      ref_pin = 2'b10;
    end else begin
      case (sl)
        3'h0: ref_pin[0] = &(s[23:20] | ~m);
        3'h1: ref_pin[0] = |(s[23:20] & m);
        3'h2: ref_pin[0] = s[45 + t];
        3'h3: ref_pin[0] = s[47 + t];
        3'h4: ref_pin[0] = s[49 + t];
        3'h5: ref_pin[0] = s[51 + t];
        default: ref_pin = 2'b10;
      endcase
    end
  endfunction

  task automatic end_of_test();
    $display("comparisons %0d errors %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic chk_reg(input string nm, input logic [7:0] e, input logic [7:0] g);
    cmp_count++;
    if (g !== e) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic chk_pin(input string nm, input logic e, input logic g);
    cmp_count++;
    if (g !== e) begin
      num_errors++;
      $display("wrong value %s expected %b seen %b", nm, e, g);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 chk_reg("reg_rdata", e, reg_rdata);
  endtask

  // Hang guard
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 20000) begin
      num_errors++;
      end_of_test();
    end
  end

  initial begin
    logic [7:0] ctl;
    logic [1:0] e;
    repeat (12) @(posedge sys_clk);
    srst <= 1'b0;
    #1 chk_pin("pin_oe", 1'b0, pin_oe);
    chk_pin("pin_out", 1'b0, pin_out);
    rd(CTL_ADDR, 8'h00);
    rd(STAT_ADDR, 8'h00);
    for (int p = 0; p < 4; p++) begin
      for (int c = 0; c < 64; c++) begin
        ctl = {c[5:0], p[1:0]};
        e = ref_pin(ctl, pats[p]);
        @(posedge sys_clk);
        stim <= pats[p];
        wr(CTL_ADDR, ctl);
        @(posedge sys_clk);
        #1 chk_pin("pin_out", e[0], pin_out);
        chk_pin("pin_oe", ctl[0], pin_oe);
        chk_pin("pin_level", ctl[0] & e[0], pin_level);
        rd(CTL_ADDR, ctl);
        rd(STAT_ADDR, {5'h00, e[1], ctl[0], e[0]});
      end
    end
    // Lock change reaches the pin one cycle later
    wr(CTL_ADDR, 8'h81);
    @(posedge sys_clk);
    stim <= 64'h0;
    @(posedge sys_clk);
    stim <= 64'h1_0000;
    #1 chk_pin("pin_out", 1'b0, pin_out);
    @(posedge sys_clk);
    #1 chk_pin("pin_out", 1'b1, pin_out);
    wr(STAT_ADDR, 8'hff);
    wr(8'h55, 8'hff);
    rd(CTL_ADDR, 8'h81);
    rd(8'h55, 8'h00);
    // Write then read with no gap between strobes
    @(posedge sys_clk);
    reg_addr <= CTL_ADDR;
    reg_wdata <= 8'h5d;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 chk_reg("reg_rdata", 8'h5d, reg_rdata);
    @(posedge sys_clk);
    srst <= 1'b1;
    repeat (2) @(posedge sys_clk);
    srst <= 1'b0;
    #1 chk_pin("pin_oe", 1'b0, pin_oe);
    rd(CTL_ADDR, 8'h00);
    end_of_test();
  end
endmodule
`default_nettype wire
